// *** hic_inquiry_control.sv ***
// Inquiry and cancel command interpreter with an Avalon-MM register slave.
// Assumes the radio offers responses by valid/ready and the host takes events by valid/ready.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module hic_inquiry_control #(
    parameter int UNIT_CYCLES = hic_pkg::INQ_UNIT_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic rspValid,
    input wire logic [47:0] rspAddr,
    output logic rspReady,
    output logic inqActive,
    output logic [23:0] inqLap,
    output logic evtValid,
    output logic [7:0] evtCode,
    output logic [7:0] evtStatus,
    output logic [47:0] evtData,
    input wire logic evtReady,
    output logic irq
);
    import hic_pkg::*;

    hic_state_e state;
    logic ackQ;
    logic [15:0] cmdOpcode;
    logic cmdPending;
    logic [23:0] lapReg;
    logic [7:0] lenReg;
    logic [7:0] numReg;
    logic [7:0] runLen;
    logic [7:0] runNum;
    logic [7:0] respCnt;
    logic [7:0] lastStatus;
    logic [EV_N-1:0] evMask;
    logic [EV_N-1:0] irqStat;
    logic [EV_N-1:0] irqEn;
    logic [47:0] filtAddr;
    logic filtEn;

    // Bus handshake: one wait cycle, command writes stall while one is pending
    wire req = read || write;
    wire cmdBlocked = write && (address == REG_CMD) && cmdPending;
    assign waitrequest = req && (!ackQ || cmdBlocked);
    wire wrDone = write && ackQ && !cmdBlocked;
    wire wrCmd = wrDone && (address == REG_CMD);
    wire wrLap = wrDone && (address == REG_LAP);
    wire wrParam = wrDone && (address == REG_PARAM);
    wire wrMask = wrDone && (address == REG_EVMASK);
    wire wrClr = wrDone && (address == REG_IRQ_CLR);
    wire wrIrqEn = wrDone && (address == REG_IRQ_EN);
    wire wrFiltLo = wrDone && (address == REG_FILT_LO);
    wire wrFiltHi = wrDone && (address == REG_FILT_HI);

    wire [31:0] statusWord = {8'h00, lastStatus, respCnt, 7'h00, state == HIC_SCAN};
    wire [31:0] readMux =
        (address == REG_CMD) ? {16'h0000, cmdOpcode} :
        (address == REG_LAP) ? {8'h00, lapReg} :
        (address == REG_PARAM) ? {16'h0000, numReg, lenReg} :
        (address == REG_EVMASK) ? {28'h0000000, evMask} :
        (address == REG_STATUS) ? statusWord :
        (address == REG_IRQ_STAT) ? {28'h0000000, irqStat} :
        (address == REG_IRQ_EN) ? {28'h0000000, irqEn} :
        (address == REG_FILT_LO) ? filtAddr[31:0] :
        (address == REG_FILT_HI) ? {15'h0000, filtEn, filtAddr[47:32]} :
        32'h00000000;

    // Command decode
    wire [5:0] cmdOgf = cmdOpcode[15:OGF_LSB];
    wire [9:0] cmdOcf = cmdOpcode[9:0];
    wire isLinkCtl = (cmdOgf == OGF_LINK_CTRL);
    wire isInquiry = isLinkCtl && (cmdOcf == OCF_INQUIRY);
    wire isCancel = isLinkCtl && (cmdOcf == OCF_INQ_CANCEL);
    wire lapOk = (lapReg >= LAP_MIN) && (lapReg <= LAP_MAX);
    wire lenOk = (lenReg >= LEN_MIN) && (lenReg <= LEN_MAX);
    wire scanning = (state == HIC_SCAN);

    // Event slot is free when nothing waits or the host takes it now
    wire slotFree = !evtValid || evtReady;
    wire doCmd = ce && cmdPending && slotFree;
    wire startInq = doCmd && isInquiry && lapOk && lenOk && !scanning;
    wire cancelInq = doCmd && isCancel && scanning;
    wire timeUp;

    // Responses
    wire seenHit;
    wire filtMiss = filtEn && (rspAddr != filtAddr);
    // Limit counts reported devices; halt follows once the last result is out
    wire limitHit = (runNum != NUM_UNLIMITED) && (respCnt == runNum);
    assign rspReady = scanning && slotFree && !cmdPending && !timeUp && !limitHit;
    wire rspTake = ce && rspValid && rspReady;
    wire rspNew = rspTake && !seenHit && !filtMiss;
    wire [7:0] nextCnt = respCnt + 8'h01;
    wire halt = ce && scanning && !cmdPending && slotFree && (timeUp || limitHit);

    // Status for the command being handled
    logic [7:0] cmdSt;
    always_comb begin
        if (!isLinkCtl || !(isInquiry || isCancel)) begin
            cmdSt = ST_UNKNOWN_CMD;
        end else if (isInquiry && !(lapOk && lenOk)) begin
            cmdSt = ST_BAD_PARAM;
        end else if (isInquiry && scanning) begin
            cmdSt = ST_BUSY;
        end else if (isCancel && !scanning) begin
            cmdSt = ST_BUSY;
        end else begin
            cmdSt = ST_OK;
        end
    end

    // Next event selection; priority command, then halt, then result
    logic evLoad;
    logic [EV_N-1:0] evKind;
    logic [7:0] next_evtCode;
    logic [7:0] next_evtStatus;
    logic [47:0] next_evtData;
    always_comb begin
        evKind = '0;
        next_evtCode = EVT_CMD_STATUS;
        next_evtStatus = cmdSt;
        next_evtData = {32'h00000000, cmdOpcode};
        if (doCmd && isCancel) begin
            evKind[EV_CMD_DONE] = 1'b1;
            next_evtCode = EVT_CMD_COMPLETE;
        end else if (doCmd) begin
            evKind[EV_STATUS] = 1'b1;
        end else if (halt) begin
            evKind[EV_COMPLETE] = 1'b1;
            next_evtCode = EVT_INQ_COMPLETE;
            next_evtStatus = ST_OK;
            next_evtData = {40'h0000000000, respCnt};
        end else if (rspNew) begin
            evKind[EV_RESULT] = 1'b1;
            next_evtCode = EVT_INQ_RESULT;
            next_evtStatus = 8'h01;
            next_evtData = rspAddr;
        end
        evLoad = |(evKind & evMask);
    end

    hic_tick #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_tick (
        .mclk(mclk),
        .nrst(nrst),
        .ce(ce),
        .start(startInq),
        .run(scanning),
        .length(runLen),
        .expired(timeUp)
    );

    hic_seen u_seen (
        .mclk(mclk),
        .nrst(nrst),
        .ce(ce),
        .clear(startInq),
        .insert(rspNew),
        .addr(rspAddr),
        .hit(seenHit)
    );

    assign inqActive = scanning;
    assign inqLap = lapReg;
    assign irq = |(irqStat & irqEn);

    // Bus registers
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ackQ <= 1'b0;
            readdata <= 32'h00000000;
        end else if (ce) begin
            ackQ <= req && !ackQ && !cmdBlocked;
            if (read && !ackQ) begin
                readdata <= readMux;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cmdOpcode <= 16'h0000;
            lapReg <= LAP_MIN;
            lenReg <= LEN_MIN;
            numReg <= NUM_UNLIMITED;
            evMask <= EVMASK_RESET;
            irqEn <= '0;
            filtAddr <= 48'h000000000000;
            filtEn <= 1'b0;
        end else if (ce) begin
            if (wrCmd) cmdOpcode <= writedata[15:0];
            if (wrLap) lapReg <= writedata[23:0];
            if (wrParam) begin
                lenReg <= writedata[7:0];
                numReg <= writedata[15:8];
            end
            if (wrMask) evMask <= writedata[EV_N-1:0];
            if (wrIrqEn) irqEn <= writedata[EV_N-1:0];
            if (wrFiltLo) filtAddr[31:0] <= writedata;
            if (wrFiltHi) begin
                filtAddr[47:32] <= writedata[15:0];
                filtEn <= writedata[FILT_EN_BIT];
            end
        end
    end

    // Sticky interrupt bits; a new event wins over a clear
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            irqStat <= '0;
        end else if (ce) begin
            irqStat <= (irqStat & ~(wrClr ? writedata[EV_N-1:0] : '0)) | (evKind & evMask);
        end
    end

    // Command pending flag
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cmdPending <= 1'b0;
        end else if (ce) begin
            if (wrCmd) begin
                cmdPending <= 1'b1;
            end else if (doCmd) begin
                cmdPending <= 1'b0;
            end
        end
    end

    // Inquiry state; cancel ends without an inquiry complete event
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= HIC_IDLE;
            runLen <= LEN_MIN;
            runNum <= NUM_UNLIMITED;
            respCnt <= 8'h00;
            lastStatus <= ST_OK;
        end else if (ce) begin
            if (doCmd) begin
                lastStatus <= cmdSt;
            end
            case (state)
                HIC_IDLE: begin
                    if (startInq) begin
                        state <= HIC_SCAN;
                        runLen <= lenReg;
                        runNum <= numReg;
                        respCnt <= 8'h00;
                    end
                end
                HIC_SCAN: begin
                    if (cancelInq) begin
                        state <= HIC_IDLE;
                    end else if (halt) begin
                        state <= HIC_IDLE;
                    end else if (rspNew) begin
                        respCnt <= nextCnt;
                    end
                end
                default: state <= HIC_IDLE;
            endcase
        end
    end

    // Event output slot
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            evtValid <= 1'b0;
            evtCode <= 8'h00;
            evtStatus <= 8'h00;
            evtData <= 48'h000000000000;
        end else if (ce) begin
            if (evLoad) begin
                evtValid <= 1'b1;
                evtCode <= next_evtCode;
                evtStatus <= next_evtStatus;
                evtData <= next_evtData;
            end else if (evtReady) begin
                evtValid <= 1'b0;
            end
        end
    end
endmodule : hic_inquiry_control

// *** hic_pkg.sv ***
// Constants for the inquiry command interpreter.
// Assumes one 100 MHz clock and an Avalon-MM register master.
// Functional notes
// - Opcode command field 0x0001 is the inquiry command with address part, length and limit.
// - Both commands belong to the link control group, group field 0x01.
// - An inquiry halts after its length times 1.28 s; the length must be 0x01 to 0x30.
// - A response limit of 0x00 is unlimited, otherwise the inquiry halts after that many.
// - The access code derives from the address part, which must be 0x9E8B00 to 0x9E8B3F.
// - A command status event is sent once the inquiry has really started.
// - Each responding device raises an inquiry result event.
// - A finished inquiry sends an inquiry complete event with the number of responders.
// - The inquiry command never gets a command complete event.
// - A responder is reported unless already reported or excluded by the host filter.
// - Repeat reports are optional; this block reports each of the first 8 distinct devices once per inquiry, and any later device on every response.
// - Opcode command field 0x0002 is the cancel command; it stops a running inquiry.
// - Cancel ends with a command complete event carrying status 0x00 or a failure code.
// - A cancelled inquiry never sends its inquiry complete event.
// - Each event is sent only when the host's event mask allows it.
package hic_pkg;
    localparam logic [5:0] OGF_LINK_CTRL = 6'h01;
    localparam logic [9:0] OCF_INQUIRY = 10'h001;
    localparam logic [9:0] OCF_INQ_CANCEL = 10'h002;
    localparam int OGF_LSB = 10;
    localparam logic [23:0] LAP_MIN = 24'h9E8B00;
    localparam logic [23:0] LAP_MAX = 24'h9E8B3F;
    localparam logic [7:0] LEN_MIN = 8'h01;
    localparam logic [7:0] LEN_MAX = 8'h30;
    localparam logic [7:0] NUM_UNLIMITED = 8'h00;
    localparam longint CLK_PERIOD_PS = 10000;
    localparam longint INQ_UNIT_PS = 1280000000000;
    localparam int INQ_UNIT_CYCLES = int'(INQ_UNIT_PS / CLK_PERIOD_PS);
    localparam int UNIT_W = 27;
    // Event codes and status values
    localparam logic [7:0] EVT_INQ_COMPLETE = 8'h01;
    localparam logic [7:0] EVT_INQ_RESULT = 8'h02;
    localparam logic [7:0] EVT_CMD_COMPLETE = 8'h0E;
    localparam logic [7:0] EVT_CMD_STATUS = 8'h0F;
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_UNKNOWN_CMD = 8'h01;
    localparam logic [7:0] ST_BUSY = 8'h0C;
    localparam logic [7:0] ST_BAD_PARAM = 8'h12;
    // Event mask and interrupt bit positions
    localparam int EV_STATUS = 0;
    localparam int EV_RESULT = 1;
    localparam int EV_COMPLETE = 2;
    localparam int EV_CMD_DONE = 3;
    localparam int EV_N = 4;
    localparam logic [EV_N-1:0] EVMASK_RESET = 4'hF;
    // Register byte offsets
    localparam logic [5:0] REG_CMD = 6'h00;
    localparam logic [5:0] REG_LAP = 6'h04;
    localparam logic [5:0] REG_PARAM = 6'h08;
    localparam logic [5:0] REG_EVMASK = 6'h0C;
    localparam logic [5:0] REG_STATUS = 6'h10;
    localparam logic [5:0] REG_IRQ_STAT = 6'h14;
    localparam logic [5:0] REG_IRQ_CLR = 6'h18;
    localparam logic [5:0] REG_IRQ_EN = 6'h1C;
    localparam logic [5:0] REG_FILT_LO = 6'h20;
    localparam logic [5:0] REG_FILT_HI = 6'h24;
    localparam int FILT_EN_BIT = 16;
    localparam int SEEN_DEPTH = 8;
    typedef enum logic {HIC_IDLE, HIC_SCAN} hic_state_e;
endpackage : hic_pkg

// *** hic_tick.sv ***
// Inquiry duration timer in 1.28 s units.
// Assumes start and run come from the controller state machine.
`timescale 1ns/1ps
module hic_tick #(
    parameter int UNIT_CYCLES = hic_pkg::INQ_UNIT_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic start,
    input wire logic run,
    input wire logic [7:0] length,
    output logic expired
);
    import hic_pkg::*;
    logic [UNIT_W-1:0] cycCnt;
    logic [7:0] unitCnt;
    wire unitEnd = (cycCnt == UNIT_W'(UNIT_CYCLES - 1));
    wire [7:0] nextUnit = unitCnt + 8'h01;

    assign expired = run && unitEnd && (nextUnit == length);

    always_ff @(posedge mclk) begin
        if (!nrst || start) begin
            cycCnt <= '0;
            unitCnt <= 8'h00;
        end else if (ce && run && !expired) begin
            // Hold at the limit until the halt is taken; a busy slot must not lose it
            cycCnt <= unitEnd ? '0 : cycCnt + UNIT_W'(1);
            if (unitEnd) begin
                unitCnt <= nextUnit;
            end
        end
    end
endmodule : hic_tick

// *** hic_seen.sv ***
// Table of device addresses already reported in the current inquiry.
// Assumes clear at inquiry start; a full table stops recording.
`timescale 1ns/1ps
module hic_seen (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic clear,
    input wire logic insert,
    input wire logic [47:0] addr,
    output logic hit
);
    import hic_pkg::*;
    logic [47:0] entry [SEEN_DEPTH];
    logic [SEEN_DEPTH-1:0] used;
    logic [$clog2(SEEN_DEPTH):0] fill;
    logic [SEEN_DEPTH-1:0] match;

    always_comb begin
        for (int i = 0; i < SEEN_DEPTH; i++) begin
            match[i] = used[i] && (entry[i] == addr);
        end
    end
    assign hit = |match;

    always_ff @(posedge mclk) begin
        if (!nrst || clear) begin
            used <= '0;
            fill <= '0;
        end else if (ce && insert && !hit && fill < SEEN_DEPTH) begin
            entry[fill[$clog2(SEEN_DEPTH)-1:0]] <= addr;
            used[fill[$clog2(SEEN_DEPTH)-1:0]] <= 1'b1;
            fill <= fill + 1'b1;
        end
    end
endmodule : hic_seen

// *** hic_inquiry_control_props.sv ***
// Port checker for the inquiry command interpreter.
// Assumes a bind to hic_inquiry_control with ce held high.
`timescale 1ns/1ps
module hic_inquiry_control_props
    import hic_pkg::*;
#(
    parameter int UNIT_CYCLES = 20
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic read,
    input wire logic waitrequest,
    input wire logic rspReady,
    input wire logic inqActive,
    input wire logic [23:0] inqLap,
    input wire logic evtValid,
    input wire logic [7:0] evtCode,
    input wire logic [7:0] evtStatus,
    input wire logic [47:0] evtData,
    input wire logic evtReady,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic [31:0] runCnt;
    always_ff @(posedge mclk) begin
        if (!nrst || !inqActive) begin
            runCnt <= 32'h0;
        end else begin
            runCnt <= runCnt + 32'h1;
        end
    end
    sequence s_stat_ok;
        evtValid && evtCode == EVT_CMD_STATUS && evtStatus == ST_OK;
    endsequence
    sequence s_one_wait;
        waitrequest ##1 !waitrequest;
    endsequence
    property p_start;
        $rose(inqActive) |-> s_stat_ok;
    endproperty
    property p_rdwait;
        $rose(read) |-> s_one_wait;
    endproperty
    property p_hold;
        evtValid && !evtReady |=> evtValid && $stable(evtCode) && $stable(evtData);
    endproperty
    property p_rsp;
        rspReady |-> inqActive && (!evtValid || evtReady);
    endproperty
    property p_cplt;
        evtValid && evtCode == EVT_INQ_COMPLETE |-> !inqActive && evtStatus == ST_OK;
    endproperty
    property p_result;
        evtValid && evtCode == EVT_INQ_RESULT |-> evtStatus == 8'h01;
    endproperty
    property p_lap;
        inqActive |-> inqLap >= LAP_MIN && inqLap <= LAP_MAX;
    endproperty
    property p_ccidle;
        evtValid && evtCode == EVT_CMD_COMPLETE |-> !inqActive;
    endproperty
    property p_time;
        inqActive |-> runCnt <= LEN_MAX * UNIT_CYCLES + 2;
    endproperty
    property p_rst;
        disable iff (1'b0) !nrst |=> !evtValid && !inqActive && !irq;
    endproperty
    a_start: assert property (p_start) else $error("no status event at start");
    a_rdwait: assert property (p_rdwait) else $error("read wait not one cycle");
    a_hold: assert property (p_hold) else $error("event changed before taken");
    a_rsp: assert property (p_rsp) else $error("response taken while not free");
    a_cplt: assert property (p_cplt) else $error("bad complete event");
    a_result: assert property (p_result) else $error("bad result status");
    a_lap: assert property (p_lap) else $error("scan with bad address part");
    a_ccidle: assert property (p_ccidle) else $error("cmd complete while scanning");
    a_time: assert property (p_time) else $error("scan overran length");
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule : hic_inquiry_control_props

// *** hic_host_model.sv ***
// Host event sink that can stall the event slot.
// Assumes events are held until evtReady is seen high.
`timescale 1ns/1ps
module hic_host_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic stall,
    input wire logic evtValid,
    input wire logic [7:0] evtCode,
    input wire logic [7:0] evtStatus,
    input wire logic [47:0] evtData,
    output logic evtReady
);
    logic [63:0] evq[$];
    always @(posedge mclk) begin
        if (!nrst) begin
            evtReady <= 1'b0;
        end else begin
            if (evtValid && evtReady) begin
                evq.push_back({evtCode, evtStatus, evtData});
            end
            evtReady <= !stall;
        end
    end
endmodule : hic_host_model

// *** hic_inquiry_control_tb.sv ***
// Testbench for the inquiry command interpreter.
// Assumes hic_host_model takes events; the bench acts as radio and bus master.
`timescale 1ns/1ps
module hic_inquiry_control_tb;
    import hic_pkg::*;
    localparam int UT = 20;
    logic mclk, nrst, ce, read, write, waitrequest, rspValid, rspReady, stall;
    logic inqActive, evtValid, evtReady, irq;
    logic [5:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [47:0] rspAddr, evtData, d;
    logic [23:0] inqLap;
    logic [7:0] evtCode, evtStatus;
    int num_errors = 0;
    int checks_done = 0;
    hic_inquiry_control #(.UNIT_CYCLES(UT)) i_dut (.mclk(mclk), .nrst(nrst), .ce(ce),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .rspValid(rspValid),
        .rspAddr(rspAddr), .rspReady(rspReady), .inqActive(inqActive), .inqLap(inqLap),
        .evtValid(evtValid), .evtCode(evtCode), .evtStatus(evtStatus),
        .evtData(evtData), .evtReady(evtReady), .irq(irq));
    hic_host_model i_host (.mclk(mclk), .nrst(nrst), .stall(stall), .evtValid(evtValid),
        .evtCode(evtCode), .evtStatus(evtStatus), .evtData(evtData), .evtReady(evtReady));
    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
        bit done;
        done = 0;
        @(posedge mclk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= wd;
        while (!done) begin
            @(posedge mclk);
            done = (waitrequest === 1'b0);
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic offer(input logic [47:0] a);
        bit done;
        done = 0;
        @(posedge mclk);
        rspValid <= 1'b1;
        rspAddr <= a;
        while (!done) begin
            @(posedge mclk);
            done = (rspReady === 1'b1);
        end
        rspValid <= 1'b0;
        rspAddr <= ~a;
    endtask : offer
    task automatic ev(input logic [7:0] c, input logic [7:0] s);
        logic [63:0] e;
        int n;
        n = 0;
        e = '1;
        while (i_host.evq.size() == 0 && n < 1000) begin
            @(posedge mclk);
            n++;
        end
        if (i_host.evq.size() != 0) begin
            e = i_host.evq.pop_front();
        end
        chk("event code", c, e[63:56]);
        chk("event status", s, e[55:48]);
        d = e[47:0];
    endtask : ev
    task automatic inq(input logic [7:0] len, input logic [7:0] num);
        bus(1, REG_PARAM, {16'h0, num, len});
        bus(1, REG_CMD, 32'h0401);
    endtask : inq
    task automatic s_regs;
        bus(0, REG_LAP, 0);
        chk("lap reset", 48'h9E8B00, rd);
        bus(0, REG_PARAM, 0);
        chk("param reset", 48'h1, rd);
        bus(0, REG_IRQ_EN, 0);
        chk("irq enable reset", 48'h0, rd);
        bus(0, REG_EVMASK, 0);
        chk("event mask reset", 48'hF, rd);
        bus(0, 6'h3C, 0);
        chk("unmapped read", 48'h0, rd);
    endtask : s_regs
    task automatic s_limit;
        inq(8'h30, 8'h02);
        ev(EVT_CMD_STATUS, ST_OK);
        chk("status data", 48'h0401, d);
        stall <= 1'b1;
        offer(48'hA1);
        repeat (4) @(posedge mclk);
        chk("held result", 48'h1, evtValid);
        stall <= 1'b0;
        offer(48'hA1);
        offer(48'hB2);
        ev(EVT_INQ_RESULT, 8'h01);
        chk("first address", 48'hA1, d);
        ev(EVT_INQ_RESULT, 8'h01);
        chk("second address", 48'hB2, d);
        ev(EVT_INQ_COMPLETE, ST_OK);
        chk("responders", 48'h2, d[7:0]);
        chk("idle after limit", 48'h0, inqActive);
    endtask : s_limit
    task automatic s_time;
        int n;
        n = 0;
        inq(8'h02, 8'h00);
        ev(EVT_CMD_STATUS, ST_OK);
        offer(48'hC3);
        ev(EVT_INQ_RESULT, 8'h01);
        while (inqActive !== 1'b0 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        chk("duration", 48'h1, n >= 2 * UT - 8 && n <= 2 * UT);
        ev(EVT_INQ_COMPLETE, ST_OK);
        chk("responders", 48'h1, d[7:0]);
        repeat (10) @(posedge mclk);
        chk("no extra event", 48'h0, i_host.evq.size());
    endtask : s_time
    task automatic s_bad;
        inq(8'h00, 8'h00);
        ev(EVT_CMD_STATUS, ST_BAD_PARAM);
        inq(8'h31, 8'h00);
        ev(EVT_CMD_STATUS, ST_BAD_PARAM);
        bus(1, REG_LAP, 32'h9E8B40);
        inq(8'h01, 8'h00);
        ev(EVT_CMD_STATUS, ST_BAD_PARAM);
        bus(1, REG_CMD, 32'h0801);
        ev(EVT_CMD_STATUS, ST_UNKNOWN_CMD);
        bus(1, REG_CMD, 32'h0403);
        ev(EVT_CMD_STATUS, ST_UNKNOWN_CMD);
        bus(1, REG_LAP, 32'h9E8B3F);
    endtask : s_bad
    task automatic s_cancel;
        inq(8'h30, 8'h00);
        ev(EVT_CMD_STATUS, ST_OK);
        chk("access code source", 48'h9E8B3F, inqLap);
        bus(1, REG_CMD, 32'h0401);
        ev(EVT_CMD_STATUS, ST_BUSY);
        bus(1, REG_CMD, 32'h0402);
        ev(EVT_CMD_COMPLETE, ST_OK);
        chk("stopped", 48'h0, inqActive);
        repeat (100) @(posedge mclk);
        chk("no complete event", 48'h0, i_host.evq.size());
        bus(1, REG_CMD, 32'h0402);
        ev(EVT_CMD_COMPLETE, ST_BUSY);
    endtask : s_cancel
    task automatic s_filter;
        bus(1, REG_FILT_LO, 32'h000000D4);
        bus(1, REG_FILT_HI, 32'h00010000);
        inq(8'h30, 8'h00);
        ev(EVT_CMD_STATUS, ST_OK);
        offer(48'hE5);
        offer(48'hD4);
        ev(EVT_INQ_RESULT, 8'h01);
        chk("filtered address", 48'hD4, d);
        bus(0, REG_STATUS, 0);
        chk("filtered count", 48'h1, rd[15:8]);
        bus(1, REG_FILT_HI, 32'h0);
        bus(1, REG_CMD, 32'h0402);
        ev(EVT_CMD_COMPLETE, ST_OK);
    endtask : s_filter
    task automatic s_irq;
        bus(1, REG_IRQ_CLR, 32'hF);
        bus(1, REG_EVMASK, 32'h7);
        bus(1, REG_IRQ_EN, 32'h9);
        chk("irq cleared", 48'h0, irq);
        inq(8'h30, 8'h00);
        ev(EVT_CMD_STATUS, ST_OK);
        @(negedge mclk);
        chk("irq set", 48'h1, irq);
        bus(0, REG_IRQ_STAT, 0);
        chk("irq status", 48'h1, rd);
        bus(1, REG_IRQ_CLR, 32'h1);
        bus(1, REG_CMD, 32'h0402);
        repeat (20) @(posedge mclk);
        chk("masked complete", 48'h0, i_host.evq.size());
        chk("irq after mask", 48'h0, irq);
        bus(0, REG_STATUS, 0);
        chk("cancel status", 48'h0, rd[23:16]);
        chk("scan bit", 48'h0, rd[0]);
    endtask : s_irq
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (30000) @(posedge mclk);
        num_errors++;
        complete_run;
    end
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 6'h0;
        writedata = 32'h0;
        rspValid = 1'b0;
        rspAddr = 48'h0;
        stall = 1'b0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        s_regs;
        s_limit;
        s_time;
        s_bad;
        s_cancel;
        s_filter;
        s_irq;
        complete_run;
    end
endmodule : hic_inquiry_control_tb
bind hic_inquiry_control hic_inquiry_control_props #(.UNIT_CYCLES(UNIT_CYCLES)) i_props (
    .mclk(mclk), .nrst(nrst), .read(read), .waitrequest(waitrequest),
    .rspReady(rspReady), .inqActive(inqActive), .inqLap(inqLap), .evtValid(evtValid),
    .evtCode(evtCode), .evtStatus(evtStatus), .evtData(evtData), .evtReady(evtReady),
    .irq(irq));
